// File: dup_uart.sv
// two serial channels with modem lines, behind an AXI4-Lite slave
// Contract
// - Data bit zero is the LSB and goes first on the serial line.
// - Modem control bit 0 set drives terminal-ready low; cleared or reset drives it high.
// - Channel interrupt drives only with modem control bit 3, from enabled sources.
// - Channel interrupt is undriven after reset and while modem control bit 3 is 0.
// - Sources: receive error, receive data, transmit space, modem status change.
// - A read returns the addressed register of the selected channel.
// - A write stores bus data into the addressed register of the selected channel.
// - User output is low with modem control bit 3 set, high otherwise and after reset.
// - Reset clears registers and outputs, parks transmit line, ignores receive line.
// - Ring input rising low to high flags a modem status change; level is reported.
// - Data-set-ready low means modem ready; its state shows in modem status.
// - Modem control bit 1 set drives request-to-send low; reset drives it high.
// - Request-to-send follows receive room only with enhanced feature bit 6.
// - Loopback ignores the receive pin and feeds transmit data to the receiver.
// - Receive-ready low when data waits; high when empty or holding an error.
// - Transmit-ready low while holding space is free, high when full.
// - Clear-to-send gates transmit only with enhanced feature bit 7; shown in status bit 4.
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module dup_uart import dup_pkg::*; #(
    parameter int CLKS_PER_BIT = CLKS_PER_BIT_DEF
) (
    input wire logic aclk, // clock, 100 MHz
    input wire logic aresetn, // synchronous reset, low
    input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // byte enables
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [AXI_ADDR_W-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    output logic [NUM_CH-1:0] tx_out, // serial transmit lines
    input wire logic [NUM_CH-1:0] rx_in, // serial receive lines
    input wire logic [NUM_CH-1:0] cts_n, // clear to send, low
    input wire logic [NUM_CH-1:0] dsr_n, // data set ready, low
    input wire logic [NUM_CH-1:0] ri_n, // ring indicator, low
    input wire logic [NUM_CH-1:0] cd_n, // carrier detect, low
    output logic [NUM_CH-1:0] dtr_n, // data terminal ready, low
    output logic [NUM_CH-1:0] rts_n, // request to send, low
    output logic [NUM_CH-1:0] user_output_n, // user output, low
    output logic [NUM_CH-1:0] channel_irq_o, // channel interrupt level
    output logic [NUM_CH-1:0] channel_irq_oe, // channel interrupt drive enable
    output logic [NUM_CH-1:0] rx_dma_ready_n, // receive ready, low
    output logic [NUM_CH-1:0] tx_dma_ready_n, // transmit ready, low
    output logic irq // unmasked event pending
);
    logic aw_hold_r;
    logic w_hold_r;
    logic [AXI_ADDR_W-1:0] awaddr_r;
    logic [7:0] wdata_r;
    logic wstrb0_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [7:0] rdata_r;
    logic [7:0] ch_rd [NUM_CH];
    logic [NUM_CH-1:0] ch_irq;

    // top address bits must be zero; everything below is mapped
    wire wr_fire = aw_hold_r && w_hold_r && !bvalid_r;
    wire wr_ok = awaddr_r[AXI_ADDR_W-1:CH_SEL_BIT+1] == '0;
    wire wr_en = wr_fire && wr_ok && wstrb0_r;
    wire wr_ch = awaddr_r[CH_SEL_BIT];
    wire [2:0] wr_idx = awaddr_r[CH_SEL_BIT-1:2];
    wire rd_fire = s_axi_arvalid && !rvalid_r;
    wire rd_ok = s_axi_araddr[AXI_ADDR_W-1:CH_SEL_BIT+1] == '0;
    wire rd_ch = s_axi_araddr[CH_SEL_BIT];
    wire [2:0] rd_idx = s_axi_araddr[CH_SEL_BIT-1:2];
    wire rd_en = rd_fire && rd_ok;

    assign s_axi_awready = !aw_hold_r && !bvalid_r;
    assign s_axi_wready = !w_hold_r && !bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = {24'h00_0000, rdata_r};
    assign irq = |ch_irq;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= 8'h00;
            wstrb0_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r <= 1'b1;
                wdata_r <= s_axi_wdata[7:0];
                wstrb0_r <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= 8'h00;
        end else if (rd_fire) begin
            rvalid_r <= 1'b1;
            rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            rdata_r <= rd_ok ? ch_rd[rd_ch] : 8'h00;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        logic [7:0] ier_r;
        logic [7:0] mcr_r;
        logic [7:0] efr_r;
        logic [3:0] evt_r;
        logic [3:0] mask_r;
        logic [3:0] src_prev_r;
        logic [7:0] rxd_r;
        logic rxv_r;
        logic ovr_r;
        logic fe_r;
        logic [7:0] thr_r;
        logic thv_r;
        logic [3:0] mmeta_r;
        logic [3:0] msync_r;
        logic [3:0] mprev_r;
        logic [3:0] dmsr_r;
        logic dtr_r;
        logic rts_r;
        logic op_r;
        logic irqo_r;
        logic irqoe_r;
        logic rx_dma_ready_n_r;
        logic tx_dma_ready_n_r;
        logic tx_busy;
        logic tx_line;
        logic rx_valid;
        logic [7:0] rx_byte;
        logic rx_ferr;

        wire we = wr_en && wr_ch == 1'(i);
        wire re = rd_en && rd_ch == 1'(i);
        wire we_data = we && wr_idx == REG_DATA;
        wire re_data = re && rd_idx == REG_DATA;
        wire re_lsr = re && rd_idx == REG_LSR;
        wire re_msr = re && rd_idx == REG_MSR;
        wire loop = mcr_r[MCR_LOOP];
        wire cts_ok = !efr_r[EFR_ACTS] || !msync_r[PIN_CTS];
        wire tx_go = thv_r && !tx_busy && cts_ok;
        wire [3:0] src = {|dmsr_r, ovr_r || fe_r, !thv_r, rxv_r};
        wire [3:0] evt_clr = (we && wr_idx == REG_EVT) ? wdata_r[3:0] : 4'h0;
        // ring flags only the trailing edge, others any change
        wire [3:0] mdelta = {msync_r[3] ^ mprev_r[3], msync_r[PIN_RI] && !mprev_r[PIN_RI],
            msync_r[1] ^ mprev_r[1], msync_r[PIN_CTS] ^ mprev_r[PIN_CTS]};
        // auto mode drops the request while the single receive slot is occupied
        wire rts_act = efr_r[EFR_ARTS] ? mcr_r[MCR_RTS] && !rxv_r : mcr_r[MCR_RTS];
        wire [7:0] lsr = {1'b0, !thv_r && !tx_busy, !thv_r, 1'b0, fe_r, 1'b0, ovr_r, rxv_r};
        wire [7:0] modem_status_reg = {~msync_r, dmsr_r};

        assign ch_rd[i] = rd_idx == REG_DATA ? rxd_r :
            rd_idx == REG_IER ? ier_r :
            rd_idx == REG_MCR ? mcr_r :
            rd_idx == REG_EFR ? efr_r :
            rd_idx == REG_LSR ? lsr :
            rd_idx == REG_MSR ? modem_status_reg :
            rd_idx == REG_EVT ? {4'h0, evt_r} : {4'h0, mask_r};
        assign ch_irq[i] = |(evt_r & mask_r);
        assign tx_out[i] = tx_line || loop; // line parked high in loopback
        assign dtr_n[i] = dtr_r;
        assign rts_n[i] = rts_r;
        assign user_output_n[i] = op_r;
        assign channel_irq_o[i] = irqo_r;
        assign channel_irq_oe[i] = irqoe_r;
        assign rx_dma_ready_n[i] = rx_dma_ready_n_r;
        assign tx_dma_ready_n[i] = tx_dma_ready_n_r;

        dup_serial #(
            .CLKS_PER_BIT(CLKS_PER_BIT)
        ) u_serial (
            .aclk(aclk),
            .aresetn(aresetn),
            .tx_start(tx_go),
            .tx_byte(thr_r),
            .tx_busy(tx_busy),
            .tx_line(tx_line),
            .rx_pin(rx_in[i]),
            .loopback(loop),
            .rx_valid(rx_valid),
            .rx_byte(rx_byte),
            .rx_ferr(rx_ferr)
        );

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                ier_r <= REG8_RST;
                mcr_r <= REG8_RST;
                efr_r <= REG8_RST;
                mask_r <= REG4_RST;
            end else if (we) begin
                if (wr_idx == REG_IER) ier_r <= wdata_r;
                if (wr_idx == REG_MCR) mcr_r <= wdata_r;
                if (wr_idx == REG_EFR) efr_r <= wdata_r;
                if (wr_idx == REG_MASK) mask_r <= wdata_r[3:0];
            end
        end

        // a new byte wins over the read that empties the slot
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                rxd_r <= 8'h00;
                rxv_r <= 1'b0;
                ovr_r <= 1'b0;
                fe_r <= 1'b0;
            end else begin
                if (rx_valid) rxd_r <= rx_byte;
                rxv_r <= rx_valid || (rxv_r && !re_data);
                ovr_r <= (rx_valid && rxv_r && !re_data) || (ovr_r && !re_lsr);
                fe_r <= (rx_valid && rx_ferr) || (fe_r && !re_lsr);
            end
        end

        // one holding slot; a write while full is dropped
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                thr_r <= 8'h00;
                thv_r <= 1'b0;
            end else if (we_data && !thv_r) begin
                thr_r <= wdata_r;
                thv_r <= 1'b1;
            end else if (tx_go) begin
                thv_r <= 1'b0;
            end
        end

        // two-flop sync; deltas read only the second stage onward
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                mmeta_r <= 4'hf;
                msync_r <= 4'hf;
                mprev_r <= 4'hf;
                dmsr_r <= 4'h0;
            end else begin
                mmeta_r <= {cd_n[i], ri_n[i], dsr_n[i], cts_n[i]};
                msync_r <= mmeta_r;
                mprev_r <= msync_r;
                dmsr_r <= mdelta | (re_msr ? 4'h0 : dmsr_r);
            end
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                evt_r <= 4'h0;
                src_prev_r <= 4'h0;
            end else begin
                src_prev_r <= src;
                evt_r <= (src & ~src_prev_r) | (evt_r & ~evt_clr);
            end
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                dtr_r <= 1'b1;
                rts_r <= 1'b1;
                op_r <= 1'b1;
                irqo_r <= 1'b0;
                irqoe_r <= 1'b0;
                rx_dma_ready_n_r <= 1'b1;
                tx_dma_ready_n_r <= 1'b1;
            end else begin
                dtr_r <= !mcr_r[MCR_DTR];
                rts_r <= !rts_act;
                op_r <= !mcr_r[MCR_OUT];
                irqo_r <= mcr_r[MCR_OUT] && |(ier_r[3:0] & src);
                irqoe_r <= mcr_r[MCR_OUT];
                rx_dma_ready_n_r <= !(rxv_r && !ovr_r && !fe_r);
                tx_dma_ready_n_r <= thv_r;
            end
        end
    end
endmodule : dup_uart
`default_nettype wire

// File: dup_pkg.sv
// constants shared by the dual serial channel block
package dup_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int BIT_TIME_NS = 8680;
    localparam int CLKS_PER_BIT_DEF = BIT_TIME_NS / CLK_PERIOD_NS;
    localparam int NUM_CH = 2;
    localparam int AXI_ADDR_W = 8;
    localparam int CH_SEL_BIT = 5;
    // per-channel word index, byte address = (ch << 5) | (index << 2)
    localparam logic [2:0] REG_DATA = 3'h0;
    localparam logic [2:0] REG_IER = 3'h1;
    localparam logic [2:0] REG_MCR = 3'h2;
    localparam logic [2:0] REG_EFR = 3'h3;
    localparam logic [2:0] REG_LSR = 3'h4;
    localparam logic [2:0] REG_MSR = 3'h5;
    localparam logic [2:0] REG_EVT = 3'h6;
    localparam logic [2:0] REG_MASK = 3'h7;
    localparam int MCR_DTR = 0;
    localparam int MCR_RTS = 1;
    localparam int MCR_OUT = 3;
    localparam int MCR_LOOP = 4;
    localparam int EFR_ARTS = 6;
    localparam int EFR_ACTS = 7;
    localparam int SRC_RXD = 0;
    localparam int SRC_TXE = 1;
    localparam int SRC_RXE = 2;
    localparam int SRC_MOD = 3;
    localparam int LSR_DR = 0;
    localparam int LSR_OE = 1;
    localparam int LSR_FE = 3;
    localparam int LSR_THRE = 5;
    localparam int LSR_TEMT = 6;
    // modem pin order in the sync vector: cts, dsr, ri, cd
    localparam int PIN_CTS = 0;
    localparam int PIN_RI = 2;
    localparam logic [7:0] REG8_RST = 8'h00;
    localparam logic [3:0] REG4_RST = 4'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : dup_pkg

// File: dup_serial.sv
// serial engine of one channel: transmitter, receiver, loopback
`timescale 1ns/1ps
`default_nettype none
module dup_serial import dup_pkg::*; #(
    parameter int CLKS_PER_BIT = CLKS_PER_BIT_DEF
) (
    input wire logic aclk, // clock
    input wire logic aresetn, // synchronous reset, low
    input wire logic tx_start, // launch tx_byte when idle
    input wire logic [7:0] tx_byte, // byte to send
    output logic tx_busy, // shifter active
    output logic tx_line, // serial out, idle high
    input wire logic rx_pin, // raw receive pin
    input wire logic loopback, // route tx into rx
    output logic rx_valid, // one-cycle byte strobe
    output logic [7:0] rx_byte, // received byte
    output logic rx_ferr // stop bit was low
);
    localparam int CW = $clog2(CLKS_PER_BIT) + 1;
    localparam logic [CW-1:0] LAST = CW'(CLKS_PER_BIT - 1);
    localparam logic [CW-1:0] HALF = CW'(CLKS_PER_BIT / 2);
    typedef enum {SER_IDLE, SER_START, SER_DATA, SER_STOP} dup_ser_type;

    if (CLKS_PER_BIT < 4) begin : g_chk
        $error("CLKS_PER_BIT must be at least 4");
    end

    dup_ser_type tst_r;
    dup_ser_type rst_r;
    logic [CW-1:0] tcnt_r;
    logic [CW-1:0] rcnt_r;
    logic [2:0] tbit_r;
    logic [2:0] rbit_r;
    logic [7:0] tsh_r;
    logic [7:0] rsh_r;
    logic tline_r;
    logic rmeta_r;
    logic rsync_r;
    logic rvld_r;
    logic rfe_r;
    wire rx_src = loopback ? tline_r : rsync_r; // external pin ignored in loopback
    wire tdone = tcnt_r == LAST;
    wire rmid = rcnt_r == HALF;
    wire rend = rcnt_r == LAST;

    assign tx_busy = tst_r != SER_IDLE;
    assign tx_line = tline_r;
    assign rx_valid = rvld_r;
    assign rx_byte = rsh_r;
    assign rx_ferr = rfe_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tst_r <= SER_IDLE;
            tcnt_r <= '0;
            tbit_r <= 3'h0;
            tsh_r <= 8'h00;
            tline_r <= 1'b1;
        end else begin
            tcnt_r <= (tst_r == SER_IDLE || tdone) ? '0 : tcnt_r + 1'b1;
            case (tst_r)
                SER_IDLE: if (tx_start) begin
                    tsh_r <= tx_byte;
                    tline_r <= 1'b0;
                    tst_r <= SER_START;
                end
                SER_START: if (tdone) begin
                    tline_r <= tsh_r[0];
                    tsh_r <= {1'b0, tsh_r[7:1]};
                    tbit_r <= 3'h0;
                    tst_r <= SER_DATA;
                end
                SER_DATA: if (tdone) begin
                    tbit_r <= tbit_r + 3'h1;
                    tline_r <= (tbit_r == 3'h7) ? 1'b1 : tsh_r[0];
                    tsh_r <= {1'b0, tsh_r[7:1]};
                    if (tbit_r == 3'h7) tst_r <= SER_STOP;
                end
                SER_STOP: if (tdone) tst_r <= SER_IDLE;
                default: tst_r <= SER_IDLE;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rmeta_r <= 1'b1;
            rsync_r <= 1'b1;
            rst_r <= SER_IDLE;
            rcnt_r <= '0;
            rbit_r <= 3'h0;
            rsh_r <= 8'h00;
            rvld_r <= 1'b0;
            rfe_r <= 1'b0;
        end else begin
            rmeta_r <= rx_pin;
            rsync_r <= rmeta_r;
            rvld_r <= 1'b0;
            rcnt_r <= (rst_r == SER_IDLE || rend) ? '0 : rcnt_r + 1'b1;
            case (rst_r)
                SER_IDLE: if (!rx_src) rst_r <= SER_START;
                // false start: line back high at mid start bit
                SER_START: if (rmid && rx_src) rst_r <= SER_IDLE;
                    else if (rend) begin
                        rbit_r <= 3'h0;
                        rst_r <= SER_DATA;
                    end
                SER_DATA: if (rmid) begin
                    rsh_r <= {rx_src, rsh_r[7:1]};
                    rbit_r <= rbit_r + 3'h1;
                end else if (rend && rbit_r == 3'h0) rst_r <= SER_STOP;
                SER_STOP: if (rmid) begin
                    rvld_r <= 1'b1;
                    rfe_r <= !rx_src;
                    rst_r <= SER_IDLE;
                end
                default: rst_r <= SER_IDLE;
            endcase
        end
    end
endmodule : dup_serial
`default_nettype wire

// File: dup_uart_checker.sv
// port-level assertions for the dual serial channel block
`timescale 1ns/1ps
`default_nettype none
module dup_uart_checker import dup_pkg::*; #(
    parameter int CLKS_PER_BIT = CLKS_PER_BIT_DEF
) (
    input wire logic aclk, // clock
    input wire logic aresetn, // reset, low
    input wire logic s_axi_awvalid, // aw valid
    input wire logic s_axi_awready, // aw ready
    input wire logic s_axi_bvalid, // b valid
    input wire logic s_axi_bready, // b ready
    input wire logic s_axi_arvalid, // ar valid
    input wire logic s_axi_arready, // ar ready
    input wire logic [31:0] s_axi_rdata, // read data
    input wire logic s_axi_rvalid, // r valid
    input wire logic [NUM_CH-1:0] tx_out, // serial out
    input wire logic [NUM_CH-1:0] dtr_n, // terminal ready
    input wire logic [NUM_CH-1:0] rts_n, // request to send
    input wire logic [NUM_CH-1:0] user_output_n, // user output
    input wire logic [NUM_CH-1:0] channel_irq_o, // channel irq
    input wire logic [NUM_CH-1:0] channel_irq_oe // irq drive enable
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // own disable: this one must hold while reset is low
    property p_rst;
        @(posedge aclk) disable iff (1'b0)
        !aresetn |=> {tx_out, dtr_n, rts_n, user_output_n, channel_irq_oe} == 10'h3fc;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not at reset level");
    property p_oe;
        (channel_irq_o & ~channel_irq_oe) == 2'h0;
    endproperty
    a_oe: assert property (p_oe) else $error("irq high while undriven");
    property p_op;
        $fell(user_output_n[0]) |-> ##[0:1] channel_irq_oe[0];
    endproperty
    a_op: assert property (p_op) else $error("user output low without irq drive");
    property p_b;
        s_axi_awvalid && s_axi_awready |-> ##2 s_axi_bvalid;
    endproperty
    a_b: assert property (p_b) else $error("write response late");
    property p_bone;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_bone: assert property (p_bone) else $error("write response repeated");
    property p_r;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_r: assert property (p_r) else $error("read data late");
    property p_ar;
        s_axi_rvalid |-> !s_axi_arready && s_axi_rdata[31:8] == 24'h00_0000;
    endproperty
    a_ar: assert property (p_ar) else $error("read channel misbehaves");
    // four is the shortest bit time the engine allows
    property p_start;
        $fell(tx_out[0]) |-> (!tx_out[0]) [*4];
    endproperty
    a_start: assert property (p_start) else $error("start bit too short");
endmodule : dup_uart_checker
bind dup_uart dup_uart_checker #(.CLKS_PER_BIT(CLKS_PER_BIT)) u_chk (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .tx_out, .dtr_n,
    .rts_n, .user_output_n, .channel_irq_o, .channel_irq_oe
);
`default_nettype wire

// File: dup_modem_model.sv
// far-end serial partner: hears the transmit line, drives the receive line
`timescale 1ns/1ps
`default_nettype none
module dup_modem_model #(
    parameter int CPB = 8
) (
    input wire logic aclk, // clock
    input wire logic tx_line, // device serial out
    output logic rx_line, // device serial in
    output logic [7:0] got, // last byte heard
    output int n_got // bytes heard
);
    initial begin
        rx_line = 1'b1;
        got = 8'h00;
        n_got = 0;
    end
    // sample mid-bit so edge jitter of a cycle cannot flip a bit
    always begin
        @(negedge tx_line);
        repeat (CPB / 2) @(posedge aclk);
        for (int i = 0; i < 8; i++) begin
            repeat (CPB) @(posedge aclk);
            got[i] = tx_line;
        end
        repeat (CPB) @(posedge aclk);
        n_got = n_got + 1;
    end
    // stop low only when a framing fault is wanted; line idles high after
    task automatic send(input logic [7:0] b, input logic stop);
        logic [9:0] f;
        f = {stop, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rx_line <= f[i];
            repeat (CPB) @(posedge aclk);
        end
        rx_line <= 1'b1;
    endtask : send
endmodule : dup_modem_model
`default_nettype wire

// File: test_dual_uart_pin_interface.sv
// self-checking bench for the dual serial channel block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
    $display("[FAIL] %0t got %h want %h", $time, (a), (b)); end end
module test_dual_uart_pin_interface import dup_pkg::*;;
    localparam int CPB = 8;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic [1:0] cts_n = 2'h3, dsr_n = 2'h3, ri_n = 2'h3, cd_n = 2'h3;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, tx_out, dtr_n, rts_n, op_n, irq_o, irq_oe, rxr_n, txr_n, r;
    logic [31:0] rdata, d;
    wire logic rx0;
    wire logic [7:0] got;
    int n_got, n0, n_fail = 0, samples_checked = 0;
    // mcr value beside expected {dtr_n, rts_n, user_output_n, irq_oe} of channel 0
    logic [11:0] rows [5] = '{12'h00e, 12'h016, 12'h02a, 12'h08d, 12'h0b1};
    dup_uart #(.CLKS_PER_BIT(CPB)) DUT (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
        .tx_out(tx_out), .rx_in({1'b1, rx0}), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n),
        .cd_n(cd_n), .dtr_n(dtr_n), .rts_n(rts_n), .user_output_n(op_n),
        .channel_irq_o(irq_o), .channel_irq_oe(irq_oe), .rx_dma_ready_n(rxr_n),
        .tx_dma_ready_n(txr_n), .irq(irq)
    );
    dup_modem_model #(.CPB(CPB)) u_modem (
        .aclk(aclk), .tx_line(tx_out[0]), .rx_line(rx0), .got(got), .n_got(n_got)
    );
    function automatic logic [7:0] ad(input logic ch, input logic [2:0] idx);
        return {2'b00, ch, idx, 2'b00};
    endfunction : ad
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        awaddr <= a;
        wdata <= {24'h00_0000, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
    endtask : rd
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report
    initial begin
        forever #5 aclk = ~aclk;
    end
    // generous: every frame is ten bit times of CPB cycles
    initial begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        final_report();
    end
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        foreach (rows[i]) begin
            wr(ad(1'b0, REG_MCR), rows[i][11:4]);
            repeat (2) @(posedge aclk);
            `CHK({dtr_n[0], rts_n[0], op_n[0], irq_oe[0]}, rows[i][3:0])
            `CHK({dtr_n[1], rts_n[1], op_n[1], irq_oe[1]}, 4'he)
            rd(ad(1'b0, REG_MCR));
            `CHK(d, {24'h00_0000, rows[i][11:4]})
        end
        wr(ad(1'b0, REG_IER), 8'h02);
        repeat (2) @(posedge aclk);
        `CHK(irq_o[0], 1'b1)
        wr(ad(1'b0, REG_IER), 8'h00);
        repeat (2) @(posedge aclk);
        `CHK(irq_o[0], 1'b0)
        ri_n[0] <= 1'b0;
        repeat (4) @(posedge aclk);
        ri_n[0] <= 1'b1;
        repeat (4) @(posedge aclk);
        wr(ad(1'b0, REG_MASK), 8'h08);
        `CHK(irq, 1'b1)
        wr(ad(1'b0, REG_EVT), 8'h08);
        `CHK(irq, 1'b0)
        rd(ad(1'b0, REG_MSR));
        `CHK(d[2], 1'b1)
        wr(ad(1'b0, REG_MCR), 8'h00);
        wr(ad(1'b0, REG_EFR), 8'h80);
        `CHK(txr_n[0], 1'b0)
        n0 = n_got;
        wr(ad(1'b0, REG_DATA), 8'ha5);
        repeat (150) @(posedge aclk);
        `CHK(txr_n[0], 1'b1)
        `CHK(n_got, n0)
        cts_n[0] <= 1'b0;
        repeat (150) @(posedge aclk);
        `CHK(got, 8'ha5)
        `CHK(n_got, n0 + 1)
        wr(ad(1'b0, REG_EFR), 8'h40);
        wr(ad(1'b0, REG_MCR), 8'h02);
        repeat (2) @(posedge aclk);
        `CHK(rts_n[0], 1'b0)
        u_modem.send(8'h3c, 1'b1);
        repeat (4) @(posedge aclk);
        `CHK({rxr_n[0], rts_n[0]}, 2'b01)
        rd(ad(1'b0, REG_DATA));
        `CHK(d[7:0], 8'h3c)
        repeat (2) @(posedge aclk);
        `CHK(rxr_n[0], 1'b1)
        u_modem.send(8'h81, 1'b0);
        repeat (4) @(posedge aclk);
        `CHK(rxr_n[0], 1'b1)
        rd(ad(1'b0, REG_LSR));
        `CHK(d[3], 1'b1)
        rd(ad(1'b0, REG_DATA));
        wr(ad(1'b0, REG_MCR), 8'h10);
        n0 = n_got;
        wr(ad(1'b0, REG_DATA), 8'h5a);
        u_modem.send(8'hff, 1'b1);
        repeat (40) @(posedge aclk);
        rd(ad(1'b0, REG_DATA));
        `CHK(d[7:0], 8'h5a)
        `CHK(n_got, n0)
        dsr_n <= 2'h2;
        cd_n <= 2'h2;
        repeat (4) @(posedge aclk);
        rd(ad(1'b0, REG_MSR));
        `CHK(d[7:4], 4'hb)
        rd(8'hc0);
        `CHK(r, RESP_SLVERR)
        wr(8'hc0, 8'h01);
        `CHK(r, RESP_SLVERR)
        wr(ad(1'b1, REG_MCR), 8'h0b);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        `CHK({tx_out, dtr_n, rts_n, op_n, irq_oe, rxr_n, txr_n, irq_o, irq}, 17'h1_fe78)
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(ad(1'b1, REG_MCR));
        `CHK(d[7:0], 8'h00)
        final_report();
    end
endmodule : test_dual_uart_pin_interface
`default_nettype wire
